// [rtl/rvc_pkg.sv]
// Package for the regulator and bus-power control register
package rvc_pkg;
    localparam logic [7:0] RVC_ADDR_REGULATOR_CONTROL = 8'hc9;
    localparam logic [7:0] RVC_RESET_VALUE = 8'h00;
    localparam int RVC_BIT_OFF = 7;
    localparam int RVC_BIT_PRESENT = 6;
    localparam int RVC_BIT_POL = 5;
    localparam int RVC_BIT_LOWPWR = 4;
    localparam logic [7:0] RVC_RSVD_MASK = 8'h0f;

    // Special function register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } rvc_sfr_req_t;

    // Regulator off and low-power controls
    typedef struct packed {
        logic regulator_off;
        logic regulator_low_power_sel;
    } rvc_reg_ctrl_t;
endpackage : rvc_pkg

// [rtl/rvc_sync.sv]
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module rvc_sync (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Data
    input wire logic din,
    output logic dout
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic out_q;
    wire agree = (s2_q == s3_q);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            out_q <= 1'b0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (agree) begin
                out_q <= s3_q;
            end
        end
    end

    assign dout = out_q;
endmodule : rvc_sync

// [rtl/rvc_regulator_control.sv]
// Regulator control register with bus-power sense and interrupt
// Functional notes
// - Bit 6 reads live bus power; read-only
// - Bit 5 selects bus-power interrupt polarity
// - Bit 4 selects regulator low-power mode
// - Bits 3..0 read zero; software writes zero
// - Interrupt is level while input matches polarity
// - Reset request when enabled and polarity matches
`timescale 1ns/1ps
module rvc_regulator_control (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Special function register bus
    input wire rvc_pkg::rvc_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    // Bus power sense pin
    input wire logic bus_power_pin,
    // Regulator controls
    output rvc_pkg::rvc_reg_ctrl_t reg_ctrl,
    // Interrupt and reset
    input wire logic bus_power_irq_en,
    input wire logic usb_reset_src_en,
    output logic bus_power_irq,
    output logic bus_power_reset_req
);
    import rvc_pkg::*;

    logic off_q;
    logic off_d;
    logic pol_q;
    logic pol_d;
    logic lowpwr_q;
    logic lowpwr_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic present;

    // Sense level equals the selected polarity
    function automatic logic pol_match(input logic level, input logic pol);
        return level == pol;
    endfunction : pol_match

    // Next value of a writable bit: write data on a hit, else hold
    function automatic logic next_bit(input logic hit, input logic wbit,
                                      input logic cur);
        return hit ? wbit : cur;
    endfunction : next_bit

    // Read view with reserved bits forced low
    function automatic logic [7:0] view_of(input logic off,
                                           input logic pres,
                                           input logic pol,
                                           input logic lowpwr);
        logic [7:0] v;
        v = RVC_RESET_VALUE;
        v[RVC_BIT_OFF] = off;
        v[RVC_BIT_PRESENT] = pres;
        v[RVC_BIT_POL] = pol;
        v[RVC_BIT_LOWPWR] = lowpwr;
        return v & ~RVC_RSVD_MASK;
    endfunction : view_of

    wire sel = (sfr_req.addr == RVC_ADDR_REGULATOR_CONTROL);
    wire wr_hit = sel && sfr_req.wr;
    wire rd_hit = sel && sfr_req.rd;
    wire match = pol_match(present, pol_q);
    wire [7:0] reg_view = view_of(off_q, present, pol_q, lowpwr_q);

    rvc_sync u_sync (
        .mclk(mclk),
        .arst_n(arst_n),
        .din(bus_power_pin),
        .dout(present)
    );

    // Write decode; bit 6 and reserved bits ignore writes
    assign off_d = next_bit(wr_hit, sfr_req.wdata[RVC_BIT_OFF],
                            off_q);
    assign pol_d = next_bit(wr_hit, sfr_req.wdata[RVC_BIT_POL],
                            pol_q);
    assign lowpwr_d = next_bit(wr_hit, sfr_req.wdata[RVC_BIT_LOWPWR],
                               lowpwr_q);
    // Read view; reserved bits zero, bit 6 live
    assign rdata_d = rd_hit ? reg_view : rdata_q;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            off_q <= RVC_RESET_VALUE[RVC_BIT_OFF];
            pol_q <= RVC_RESET_VALUE[RVC_BIT_POL];
            lowpwr_q <= RVC_RESET_VALUE[RVC_BIT_LOWPWR];
            rdata_q <= RVC_RESET_VALUE;
        end else begin
            off_q <= off_d;
            pol_q <= pol_d;
            lowpwr_q <= lowpwr_d;
            rdata_q <= rdata_d;
        end
    end

    assign sfr_rdata = rdata_q;
    assign sfr_hit = sel;
    assign reg_ctrl.regulator_off = off_q;
    assign reg_ctrl.regulator_low_power_sel = lowpwr_q;
    assign bus_power_irq = bus_power_irq_en && match;
    assign bus_power_reset_req = usb_reset_src_en && match;

    // Assertions
    property p_off_follows;
        @(posedge mclk) disable iff (!arst_n)
        wr_hit |=> (reg_ctrl.regulator_off ==
                    $past(sfr_req.wdata[RVC_BIT_OFF]));
    endproperty : p_off_follows
    off_follows_a: assert property (p_off_follows)
        else $error("regulator off bit not written");

    property p_off_holds;
        @(posedge mclk) disable iff (!arst_n)
        !wr_hit |=> $stable(reg_ctrl.regulator_off);
    endproperty : p_off_holds
    off_holds_a: assert property (p_off_holds)
        else $error("regulator off changed without write");

    property p_lowpwr_follows;
        @(posedge mclk) disable iff (!arst_n)
        wr_hit |=> (reg_ctrl.regulator_low_power_sel ==
                    $past(sfr_req.wdata[RVC_BIT_LOWPWR]));
    endproperty : p_lowpwr_follows
    lowpwr_follows_a: assert property (p_lowpwr_follows)
        else $error("low power bit not written");

    property p_lowpwr_holds;
        @(posedge mclk) disable iff (!arst_n)
        !wr_hit |=> $stable(reg_ctrl.regulator_low_power_sel);
    endproperty : p_lowpwr_holds
    lowpwr_holds_a: assert property (p_lowpwr_holds)
        else $error("low power bit changed without write");

    property p_pol_follows;
        @(posedge mclk) disable iff (!arst_n)
        wr_hit |=> (pol_q == $past(sfr_req.wdata[RVC_BIT_POL]));
    endproperty : p_pol_follows
    pol_follows_a: assert property (p_pol_follows)
        else $error("polarity bit not written");

    property p_pol_holds;
        @(posedge mclk) disable iff (!arst_n)
        !wr_hit |=> $stable(pol_q);
    endproperty : p_pol_holds
    pol_holds_a: assert property (p_pol_holds)
        else $error("polarity bit changed without write");

    property p_status_read;
        @(posedge mclk) disable iff (!arst_n)
        rd_hit |=> (sfr_rdata[RVC_BIT_PRESENT] == $past(present));
    endproperty : p_status_read
    status_read_a: assert property (p_status_read)
        else $error("status bit does not show bus power");

    property p_read_view;
        @(posedge mclk) disable iff (!arst_n)
        rd_hit |=> (sfr_rdata[RVC_BIT_OFF] == $past(off_q) &&
                    sfr_rdata[RVC_BIT_POL] == $past(pol_q) &&
                    sfr_rdata[RVC_BIT_LOWPWR] == $past(lowpwr_q));
    endproperty : p_read_view
    read_view_a: assert property (p_read_view)
        else $error("read data does not show control bits");

    property p_rdata_holds;
        @(posedge mclk) disable iff (!arst_n)
        !rd_hit |=> $stable(sfr_rdata);
    endproperty : p_rdata_holds
    rdata_holds_a: assert property (p_rdata_holds)
        else $error("read data changed without read");

    property p_rsvd_zero;
        @(posedge mclk) disable iff (!arst_n)
        (sfr_rdata & RVC_RSVD_MASK) == RVC_RESET_VALUE;
    endproperty : p_rsvd_zero
    rsvd_zero_a: assert property (p_rsvd_zero)
        else $error("reserved bits read nonzero");

    property p_irq_pol_high;
        @(posedge mclk) disable iff (!arst_n)
        (bus_power_irq_en && pol_q && present) |-> bus_power_irq;
    endproperty : p_irq_pol_high
    irq_pol_high_a: assert property (p_irq_pol_high)
        else $error("high polarity interrupt missing");

    property p_irq_pol_low;
        @(posedge mclk) disable iff (!arst_n)
        (bus_power_irq_en && !pol_q && !present) |-> bus_power_irq;
    endproperty : p_irq_pol_low
    irq_pol_low_a: assert property (p_irq_pol_low)
        else $error("low polarity interrupt missing");

    property p_irq_level;
        @(posedge mclk) disable iff (!arst_n)
        (present != pol_q) |-> !bus_power_irq;
    endproperty : p_irq_level
    irq_level_a: assert property (p_irq_level)
        else $error("interrupt stays after polarity mismatch");

    property p_irq_quiet;
        @(posedge mclk) disable iff (!arst_n)
        !bus_power_irq_en |-> !bus_power_irq;
    endproperty : p_irq_quiet
    irq_quiet_a: assert property (p_irq_quiet)
        else $error("interrupt active while disabled");

    property p_rst_req;
        @(posedge mclk) disable iff (!arst_n)
        (usb_reset_src_en && pol_q && present) |-> bus_power_reset_req;
    endproperty : p_rst_req
    rst_req_a: assert property (p_rst_req)
        else $error("reset request missing");

    property p_rst_quiet;
        @(posedge mclk) disable iff (!arst_n)
        (!usb_reset_src_en || present != pol_q) |-> !bus_power_reset_req;
    endproperty : p_rst_quiet
    rst_quiet_a: assert property (p_rst_quiet)
        else $error("reset request without match");

    property p_pin_rise;
        @(posedge mclk) disable iff (!arst_n)
        $rose(bus_power_pin) ##1 bus_power_pin [*4] |-> present;
    endproperty : p_pin_rise
    pin_to_status_a: assert property (p_pin_rise)
        else $error("sense pin not seen in time");

    property p_pin_fall;
        @(posedge mclk) disable iff (!arst_n)
        $fell(bus_power_pin) ##1 (!bus_power_pin) [*4] |-> !present;
    endproperty : p_pin_fall
    pin_fall_status_a: assert property (p_pin_fall)
        else $error("sense pin removal not seen in time");

    property p_reset_clear;
        @(posedge mclk)
        (!arst_n ##1 !arst_n) |->
            (sfr_rdata == RVC_RESET_VALUE &&
             reg_ctrl.regulator_off == RVC_RESET_VALUE[RVC_BIT_OFF] &&
             reg_ctrl.regulator_low_power_sel ==
                 RVC_RESET_VALUE[RVC_BIT_LOWPWR] &&
             pol_q == RVC_RESET_VALUE[RVC_BIT_POL]);
    endproperty : p_reset_clear
    reset_clear_a: assert property (p_reset_clear)
        else $error("register not cleared by reset");

    cov_write_c: cover property (@(posedge mclk) disable iff (!arst_n)
        wr_hit ##1 off_q);
    cov_irq_c: cover property (@(posedge mclk) disable iff (!arst_n)
        $rose(bus_power_irq));
    cov_reset_c: cover property (@(posedge mclk) disable iff (!arst_n)
        $rose(bus_power_reset_req));
    cov_read_c: cover property (@(posedge mclk) disable iff (!arst_n)
        rd_hit ##1 sfr_rdata[RVC_BIT_PRESENT]);
    cov_lowpwr_c: cover property (@(posedge mclk) disable iff (!arst_n)
        wr_hit ##1 lowpwr_q);
endmodule : rvc_regulator_control

// [tb/rvc_core_model.sv]
// Processor core model driving the register bus
`timescale 1ns/1ps
module rvc_core_model (
    // Clock
    input wire logic mclk,
    // Register bus
    output rvc_pkg::rvc_sfr_req_t sfr_req
);
    import rvc_pkg::*;
    initial sfr_req = '0;
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        sfr_req <= '{a, 1'b1, 1'b0, d & ~RVC_RSVD_MASK};
        @(posedge mclk);
        sfr_req.wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge mclk);
        sfr_req <= '{a, 1'b0, 1'b1, 8'h00};
        @(posedge mclk);
        sfr_req.rd <= 1'b0;
    endtask : rd
endmodule : rvc_core_model

// [tb/tb_top.sv]
// Self-checking bench for the regulator control register
`timescale 1ns/1ps
`define CHK(a, b) n_tests++; if ((a) !== (b)) begin mismatches++; \
    $display("FAIL %0t %h %h", $time, a, b); end
module tb_top;
    import rvc_pkg::*;
    logic mclk = 0, arst_n = 0, pin = 0, en = 0, rs = 0, rd_p = 0;
    logic irq, rst_req, hit;
    logic [7:0] sfr_rdata, r = 8'h00, w;
    logic [11:0] e;
    logic [11:0] q[$];
    rvc_sfr_req_t sfr_req;
    rvc_reg_ctrl_t reg_ctrl;
    int mismatches = 0, n_tests = 0, seed = 32'h7e8c994f;
    always #20 mclk = ~mclk;
    rvc_core_model i_core (.mclk(mclk), .sfr_req(sfr_req));
    rvc_regulator_control i_dut (.mclk(mclk), .arst_n(arst_n),
        .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .sfr_hit(hit),
        .bus_power_pin(pin), .reg_ctrl(reg_ctrl),
        .bus_power_irq_en(en), .usb_reset_src_en(rs),
        .bus_power_irq(irq), .bus_power_reset_req(rst_req));
    always @(posedge mclk) rd_p <= sfr_req.rd & hit;
    always @(negedge mclk) if (rd_p) begin
        e = q.pop_front();
        `CHK(sfr_rdata, e[11:4])
        `CHK({reg_ctrl, irq, rst_req}, e[3:0])
    end
    task automatic results;
        if (mismatches == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    task automatic check_read;
        logic m;
        m = pin == r[5];
        i_core.rd(RVC_ADDR_REGULATOR_CONTROL);
        q.push_back({r[7], pin, r[5], r[4], 4'h0, r[7], r[4], en & m, rs & m});
    endtask : check_read
    initial begin
        repeat (10) @(posedge mclk);
        arst_n <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            w = 8'($random(seed));
            @(posedge mclk);
            {pin, en, rs} <= w[2:0];
            repeat (6) @(posedge mclk);
            check_read();
            w = 8'($random(seed));
            i_core.wr(RVC_ADDR_REGULATOR_CONTROL, w);
            r = w & 8'hb0;
            i_core.wr(8'hc8, ~w);
            i_core.rd(8'hca);
        end
        check_read();
        repeat (2) @(posedge mclk);
        arst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        r = 8'h00;
        repeat (6) @(posedge mclk);
        check_read();
        repeat (2) @(posedge mclk);
        results();
    end
    initial begin
        repeat (100000) @(posedge mclk);
        mismatches++;
        results();
    end
endmodule : tb_top
